// ==== port_control_line_interrupts.sv ====
// port_control_line_interrupts: port control registers, edge flags,
// strobe lines, timer status and the shared open-drain interrupt
// assumes: i_clock is the processor phase-2 clock; each selected
// clock cycle is one processor access; counter core lives outside
`timescale 1ns/100ps

// Behaviour
// [R1] three requests wire-ORed onto open-drain interrupt
// [R2] first A edge sets bit 7, bit 0 gates
// [R3] A bit 1 picks first edge polarity
// [R4] A second line input when bit 5 low
// [R5] A bit 3 gates bit 6 flag
// [R6] port A data read clears A flags
// [R7] pulse mode: low pulse per A read
// [R8] handshake: read drives A second line low
// [R9] A strobe low next edge, bit3 restores
// [R10] handshake restore on next first-line edge
// [R11] bit 4 set: static level from bit 3
// [R12] first B edge sets bit 7, bit 0 gates
// [R13] B bit 1 picks first edge polarity
// [R14] second B edge sets bit 6, bit 3 gates
// [R15] port B data read clears B flags
// [R16] B strobe pulses on port B write
// [R17] A bit 2 selects output or direction
// [R18] timer request: underflow and enable bit
// [R19] address 3: status read clears, mode write
// [R20] address 2: lower count, latch, snapshot copy
// [R21] edges found by sampling consecutive levels
module port_control_line_interrupts (
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   input  wire logic       i_chip_select,
   input  wire logic       i_chip_select_n,
   input  wire logic       i_read_write,
   input  wire logic [2:0] i_register_select,
   input  wire logic [7:0] i_data,

   output logic      [7:0] o_data,
   output logic            o_data_oe_n,

   output logic            o_irq_out,
   output logic            o_irq_oe_n,

   input  wire logic       i_port_a_edge_input,
   input  wire logic       i_port_a_strobe_line,
   output logic            o_port_a_strobe_line,
   output logic            o_port_a_strobe_oe_n,

   input  wire logic       i_port_b_edge_input,
   input  wire logic       i_port_b_strobe_line,
   output logic            o_port_b_strobe_line,
   output logic            o_port_b_strobe_oe_n,

   input  wire logic [7:0] i_port_a_pins,
   input  wire logic [7:0] i_port_b_pins,

   output logic      [7:0] o_port_a_output_reg,
   output logic      [7:0] o_port_a_direction_reg,
   output logic      [7:0] o_port_b_output_reg,
   output logic      [7:0] o_port_b_direction_reg,

   input  wire logic       i_timer_underflow,
   input  wire logic [7:0] i_lower_count,
   input  wire logic [7:0] i_upper_count,

   output logic      [7:0] o_upper_latch,
   output logic      [7:0] o_lower_reload_latch,
   output logic            o_counter_load,
   output logic      [7:0] o_timer_mode_control
);

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   logic       selected;
   logic       rd;
   logic       wr;

   logic [5:0] control   [2];

   logic [1:0] first_flag;
   logic [1:0] second_flag;
   logic [1:0] port_req;

   logic [1:0] strobe_out;
   logic [1:0] strobe_oe_n;
   logic [1:0] strobe_in;
   logic [1:0] edge_in;

   logic [1:0] access;
   logic [1:0] flag_clear;

   logic [1:0] data_hit;
   logic [1:0] ctl_hit;
   logic [1:0] out_hit;
   logic [1:0] dir_hit;

   logic       underflow_flag;
   logic       port_a_status;
   logic       timer_request;

   logic [7:0] snapshot_latch;
   logic [7:0] next_data;

   function automatic logic [7:0] pin_view(input logic [7:0] out_reg,
                                           input logic [7:0] dir_reg,
                                           input logic [7:0] pins);
      pin_view = (out_reg & dir_reg) | (pins & ~dir_reg);
   endfunction

   assign selected = i_chip_select & ~i_chip_select_n;
   assign rd       = selected & i_read_write;
   assign wr       = selected & ~i_read_write;

   assign data_hit[0] = (i_register_select == port_irq_pkg::ADDR_PORT_A_DATA);
   assign data_hit[1] = (i_register_select == port_irq_pkg::ADDR_PORT_B_DATA);
   assign ctl_hit[0]  = (i_register_select == port_irq_pkg::ADDR_PORT_A_CONTROL);
   assign ctl_hit[1]  = (i_register_select == port_irq_pkg::ADDR_PORT_B_CONTROL);

   assign edge_in     = {i_port_b_edge_input, i_port_a_edge_input};
   assign strobe_in   = {i_port_b_strobe_line, i_port_a_strobe_line};

   // ---------------------------------------------------------------
   // per-port control register and line unit
   // ---------------------------------------------------------------
   genvar p;

   generate
      for (p = 0; p < 2; p = p + 1) begin : g_port
         assign out_hit[p]    = data_hit[p] & control[p][port_irq_pkg::CTL_OUTPUT_SEL]; // [R17]
         assign dir_hit[p]    = data_hit[p] & ~control[p][port_irq_pkg::CTL_OUTPUT_SEL]; // [R17]
         assign flag_clear[p] = rd & out_hit[p]; // [R6] [R15]

         always_ff @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               control[p] <= port_irq_pkg::CTL_RESET;
            end else if (wr && ctl_hit[p]) begin
               control[p] <= i_data[port_irq_pkg::CTL_LOW_WIDTH-1:0];
            end
         end

         control_line_unit u_line (
            .i_clock       (i_clock),
            .i_nrst        (i_nrst),
            .i_control     (control[p]),
            .i_edge_input  (edge_in[p]),
            .i_strobe_in   (strobe_in[p]),
            .i_access      (access[p]),
            .i_flag_clear  (flag_clear[p]),
            .o_first_flag  (first_flag[p]),
            .o_second_flag (second_flag[p]),
            .o_request     (port_req[p]),
            .o_strobe_out  (strobe_out[p]),
            .o_strobe_oe_n (strobe_oe_n[p])
         );
      end
   endgenerate

   assign access[0] = rd & out_hit[0]; // [R7] [R8]
   assign access[1] = wr & out_hit[1]; // [R16]

   assign o_port_a_strobe_line = strobe_out[0];
   assign o_port_a_strobe_oe_n = strobe_oe_n[0];

   assign o_port_b_strobe_line = strobe_out[1];
   assign o_port_b_strobe_oe_n = strobe_oe_n[1];

   // ---------------------------------------------------------------
   // port data and direction registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_port_a_output_reg    <= port_irq_pkg::BYTE_RESET;
         o_port_a_direction_reg <= port_irq_pkg::BYTE_RESET;
         o_port_b_output_reg    <= port_irq_pkg::BYTE_RESET;
         o_port_b_direction_reg <= port_irq_pkg::BYTE_RESET;
      end else if (wr) begin
         if (out_hit[0]) begin
            o_port_a_output_reg <= i_data;
         end else if (dir_hit[0]) begin
            o_port_a_direction_reg <= i_data;
         end else if (out_hit[1]) begin
            o_port_b_output_reg <= i_data;
         end else if (dir_hit[1]) begin
            o_port_b_direction_reg <= i_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // timer registers and status
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_timer_mode_control <= port_irq_pkg::TMC_RESET;
      end else if (wr && i_register_select == port_irq_pkg::ADDR_TIMER_STATUS) begin
         o_timer_mode_control <= i_data; // [R19]
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_upper_latch        <= port_irq_pkg::BYTE_RESET;
         o_lower_reload_latch <= port_irq_pkg::BYTE_RESET;
         o_counter_load       <= 1'b0;
      end else begin
         o_counter_load <= wr && (i_register_select == port_irq_pkg::ADDR_SNAPSHOT);

         if (wr && (i_register_select == port_irq_pkg::ADDR_SNAPSHOT ||
                    i_register_select == port_irq_pkg::ADDR_UPPER)) begin
            o_upper_latch <= i_data;
         end

         if (wr && i_register_select == port_irq_pkg::ADDR_LOWER) begin
            o_lower_reload_latch <= i_data; // [R20]
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         snapshot_latch <= port_irq_pkg::BYTE_RESET;
      end else if (selected && i_register_select == port_irq_pkg::ADDR_LOWER) begin
         snapshot_latch <= i_upper_count; // [R20]
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         underflow_flag <= 1'b0;
      end else if (i_timer_underflow) begin
         underflow_flag <= 1'b1;
      end else if ((rd && i_register_select == port_irq_pkg::ADDR_TIMER_STATUS) || // [R19]
                   (selected && i_register_select == port_irq_pkg::ADDR_SNAPSHOT) ||
                   (wr && i_register_select == port_irq_pkg::ADDR_TIMER_STATUS &&
                    i_data[port_irq_pkg::TMC_MODE_MSB:0] == port_irq_pkg::TMC_MODE_DISABLED)) begin
         underflow_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         port_a_status <= 1'b0;
      end else if (first_flag[0] || second_flag[0]) begin
         port_a_status <= 1'b1;
      end else if (rd && i_register_select == port_irq_pkg::ADDR_TIMER_STATUS) begin
         port_a_status <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // read data path
   // ---------------------------------------------------------------
   always_comb begin
      next_data = port_irq_pkg::BYTE_RESET;

      if (i_register_select == port_irq_pkg::ADDR_SNAPSHOT) begin
         next_data = snapshot_latch;
      end else if (i_register_select == port_irq_pkg::ADDR_UPPER) begin
         next_data = i_upper_count;
      end else if (i_register_select == port_irq_pkg::ADDR_LOWER) begin
         next_data = i_lower_count; // [R20]
      end else if (i_register_select == port_irq_pkg::ADDR_TIMER_STATUS) begin
         next_data = {underflow_flag, port_a_status, port_irq_pkg::STATUS_FIXED_LOW}; // [R19]
      end else if (out_hit[0]) begin
         next_data = pin_view(o_port_a_output_reg, o_port_a_direction_reg, i_port_a_pins); // [R17]
      end else if (dir_hit[0]) begin
         next_data = o_port_a_direction_reg; // [R17]
      end else if (out_hit[1]) begin
         next_data = pin_view(o_port_b_output_reg, o_port_b_direction_reg, i_port_b_pins);
      end else if (dir_hit[1]) begin
         next_data = o_port_b_direction_reg;
      end else if (ctl_hit[0]) begin
         next_data = {first_flag[0], second_flag[0], control[0]};
      end else if (ctl_hit[1]) begin
         next_data = {first_flag[1], second_flag[1], control[1]};
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_data      <= port_irq_pkg::BYTE_RESET;
         o_data_oe_n <= 1'b1;
      end else begin
         o_data_oe_n <= ~rd;

         if (rd) begin
            o_data <= next_data;
         end
      end
   end

   // ---------------------------------------------------------------
   // combined interrupt output
   // ---------------------------------------------------------------
   assign timer_request = underflow_flag &
                          o_timer_mode_control[port_irq_pkg::TMC_IRQ_EN]; // [R18]
   assign o_irq_out     = 1'b0;
   assign o_irq_oe_n    = ~(port_req[0] |
                            port_req[1] |
                            timer_request); // [R1]

endmodule

// ==== port_irq_pkg.sv ====
// port_irq_pkg: register map, control field positions, status layout
// assumes: one processor access per selected clock cycle
package port_irq_pkg;

   // ---------------------------------------------------------------
   // register addresses (bank select line is address bit 2)
   // ---------------------------------------------------------------
   localparam logic [2:0] ADDR_SNAPSHOT       = 3'h0;
   localparam logic [2:0] ADDR_UPPER          = 3'h1;
   localparam logic [2:0] ADDR_LOWER          = 3'h2;
   localparam logic [2:0] ADDR_TIMER_STATUS   = 3'h3;
   localparam logic [2:0] ADDR_PORT_A_DATA    = 3'h4;
   localparam logic [2:0] ADDR_PORT_A_CONTROL = 3'h5;
   localparam logic [2:0] ADDR_PORT_B_DATA    = 3'h6;
   localparam logic [2:0] ADDR_PORT_B_CONTROL = 3'h7;

   // ---------------------------------------------------------------
   // port control register fields
   // ---------------------------------------------------------------
   localparam int CTL_FIRST_FLAG   = 7;
   localparam int CTL_SECOND_FLAG  = 6;
   localparam int CTL_OUTPUT_MODE  = 5;
   localparam int CTL_SECOND_POL   = 4;
   localparam int CTL_SECOND_EN    = 3;
   localparam int CTL_OUTPUT_SEL   = 2;
   localparam int CTL_FIRST_POL    = 1;
   localparam int CTL_FIRST_EN     = 0;
   localparam int CTL_LOW_WIDTH    = 6;
   localparam logic [5:0] CTL_RESET = 6'h00;

   // ---------------------------------------------------------------
   // timer mode control and status fields
   // ---------------------------------------------------------------
   localparam int TMC_IRQ_EN       = 7;
   localparam int TMC_MODE_MSB     = 2;
   localparam logic [2:0] TMC_MODE_DISABLED = 3'h0;
   localparam logic [7:0] TMC_RESET = 8'h00;
   localparam int STATUS_UNDERFLOW = 7;
   localparam int STATUS_PORT_A    = 6;
   localparam logic [5:0] STATUS_FIXED_LOW = 6'h1F;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // ---------------------------------------------------------------
   // strobe line sequencer
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      STROBE_HIGH = 1'b0,
      STROBE_LOW  = 1'b1
   } strobe_state_t;

endpackage

// ==== control_line_unit.sv ====
// control_line_unit: edge flags, request and strobe line of one port
// assumes: control bits and access pulses come from the register file
`timescale 1ns/100ps

module control_line_unit (
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   input  wire logic [5:0] i_control,
   input  wire logic       i_edge_input,
   input  wire logic       i_strobe_in,
   input  wire logic       i_access,
   input  wire logic       i_flag_clear,
   output logic            o_first_flag,
   output logic            o_second_flag,
   output logic            o_request,
   output logic            o_strobe_out,
   output logic            o_strobe_oe_n
);

   logic                        primed;
   logic                        edge_prev;
   logic                        strobe_prev;
   logic                        first_active;
   logic                        second_active;
   logic                        output_mode;
   logic                        pulse_mode;
   port_irq_pkg::strobe_state_t state;

   assign output_mode = i_control[port_irq_pkg::CTL_OUTPUT_MODE];
   assign pulse_mode  = output_mode & ~i_control[port_irq_pkg::CTL_SECOND_POL];

   // ---------------------------------------------------------------
   // sampled edge detection
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         primed      <= 1'b0;
         edge_prev   <= 1'b0;
         strobe_prev <= 1'b0;
      end else begin
         primed      <= 1'b1;
         edge_prev   <= i_edge_input; // [R21]
         strobe_prev <= i_strobe_in; // [R21]
      end
   end

   assign first_active = primed & (i_control[port_irq_pkg::CTL_FIRST_POL] ?
                         (~edge_prev & i_edge_input) : (edge_prev & ~i_edge_input)); // [R3] [R13]
   assign second_active = primed & ~output_mode & (i_control[port_irq_pkg::CTL_SECOND_POL] ?
                          (~strobe_prev & i_strobe_in) : (strobe_prev & ~i_strobe_in)); // [R4]

   // ---------------------------------------------------------------
   // flags: a new edge wins over a clearing read
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_first_flag <= 1'b0; // [R6] [R15]
      end else if (first_active) begin
         o_first_flag <= 1'b1; // [R2] [R12]
      end else if (i_flag_clear) begin
         o_first_flag <= 1'b0; // [R6] [R15]
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_second_flag <= 1'b0;
      end else if (second_active) begin
         o_second_flag <= 1'b1; // [R4] [R14]
      end else if (i_flag_clear || output_mode) begin
         o_second_flag <= 1'b0; // [R6] [R15]
      end
   end

   assign o_request = (o_first_flag & i_control[port_irq_pkg::CTL_FIRST_EN]) |
                      (o_second_flag & i_control[port_irq_pkg::CTL_SECOND_EN]); // [R2] [R5] [R12] [R14]

   // ---------------------------------------------------------------
   // strobe sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= port_irq_pkg::STROBE_HIGH;
      end else begin
         case (state)
            port_irq_pkg::STROBE_HIGH: begin
               if (pulse_mode && i_access) begin
                  state <= port_irq_pkg::STROBE_LOW; // [R7] [R9] [R16] [R8]
               end
            end
            port_irq_pkg::STROBE_LOW: begin
               if (!pulse_mode) begin
                  state <= port_irq_pkg::STROBE_HIGH;
               end else if (i_control[port_irq_pkg::CTL_SECOND_EN]) begin
                  state <= port_irq_pkg::STROBE_HIGH; // [R9]
               end else if (first_active) begin
                  state <= port_irq_pkg::STROBE_HIGH; // [R10]
               end
            end
            default: begin
               state <= port_irq_pkg::STROBE_HIGH;
            end
         endcase
      end
   end

   always_comb begin
      o_strobe_oe_n = ~output_mode; // [R4]
      if (!output_mode) begin
         o_strobe_out = 1'b1;
      end else if (!pulse_mode) begin
         o_strobe_out = i_control[port_irq_pkg::CTL_SECOND_EN]; // [R11]
      end else begin
         o_strobe_out = (state == port_irq_pkg::STROBE_HIGH);
      end
   end

endmodule

// ==== port_irq_monitor.sv ====
// port_irq_monitor: timing checks on the port interrupt block ports
// assumes: bound to port_control_line_interrupts, single clock domain
`timescale 1ns/100ps
module port_irq_monitor (
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   input  wire logic       i_chip_select,
   input  wire logic       i_chip_select_n,
   input  wire logic       i_read_write,
   input  wire logic [2:0] i_register_select,
   input  wire logic [7:0] i_data,
   input  wire logic [7:0] o_data,
   input  wire logic       o_data_oe_n,
   input  wire logic       o_irq_out,
   input  wire logic       o_irq_oe_n,
   input  wire logic       o_port_a_strobe_line,
   input  wire logic       o_port_b_strobe_line,
   input  wire logic       i_timer_underflow,
   input  wire logic [7:0] i_lower_count,
   input  wire logic [7:0] o_lower_reload_latch,
   input  wire logic [7:0] o_timer_mode_control
);
   logic       sel;
   logic [7:0] data_q;
   assign sel = i_chip_select & ~i_chip_select_n;
   always_ff @(posedge i_clock) begin
      data_q <= i_data;
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // ----
   // checks
   // ----
   irq_pin_low_a : assert property (o_irq_out == 1'b0)
      else $error("irq data not low");
   timer_irq_a : assert property (i_timer_underflow && o_timer_mode_control[7] &&
      !(sel && i_register_select == 3'h3) |=> !o_irq_oe_n) else $error("timer irq missing");
   status_fixed_a : assert property (sel && i_read_write && i_register_select == 3'h3 |->
      ##1 o_data[5:0] == 6'h1F) else $error("status low bits wrong");
   read_answer_a : assert property (sel && i_read_write ##1 !sel |-> !o_data_oe_n ##1 o_data_oe_n)
      else $error("read enable timing wrong");
   mode_write_a : assert property (sel && !i_read_write && i_register_select == 3'h3 |=>
      {o_timer_mode_control[7], o_timer_mode_control[2:0]} == {data_q[7], data_q[2:0]})
      else $error("mode not loaded");
   lower_read_a : assert property (sel && i_read_write && i_register_select == 3'h2 |=>
      o_data == $past(i_lower_count)) else $error("lower count read wrong");
   latch_write_a : assert property (sel && !i_read_write && i_register_select == 3'h2 |=>
      o_lower_reload_latch == data_q) else $error("lower latch not loaded");
   a_strobe_cause_a : assert property ($fell(o_port_a_strobe_line) |-> $past(sel) &&
      ($past(i_register_select) == 3'h4 || $past(i_register_select) == 3'h5)) else $error("a strobe fell");
   b_strobe_cause_a : assert property ($fell(o_port_b_strobe_line) |-> $past(sel) &&
      $past(i_register_select) >= 3'h6) else $error("b strobe fell");
endmodule

bind port_control_line_interrupts port_irq_monitor i_port_irq_monitor (.i_clock, .i_nrst, .i_chip_select,
   .i_chip_select_n, .i_read_write, .i_register_select, .i_data, .o_data, .o_data_oe_n, .o_irq_out,
   .o_irq_oe_n, .o_port_a_strobe_line, .o_port_b_strobe_line, .i_timer_underflow, .i_lower_count,
   .o_lower_reload_latch, .o_timer_mode_control);

// ==== peripheral_model.sv ====
// peripheral_model: peripheral side of both control line pairs
// assumes: a released strobe line shows the peripheral's own level
`timescale 1ns/100ps
module peripheral_model (
   input  wire logic i_clock,
   input  wire logic i_a_out,
   input  wire logic i_a_oe_n,
   input  wire logic i_b_out,
   input  wire logic i_b_oe_n,
   output logic      o_a_edge,
   output logic      o_a_line,
   output logic      o_b_edge,
   output logic      o_b_line
);
   logic a_own = 1'b1;
   logic b_own = 1'b1;
   initial begin
      o_a_edge = 1'b1;
      o_b_edge = 1'b1;
   end
   assign o_a_line = i_a_oe_n ? a_own : i_a_out;
   assign o_b_line = i_b_oe_n ? b_own : i_b_out;
   // level held three cycles
   task automatic drive(input int n, input logic v);
      @(posedge i_clock);
      #1;
      case (n)
         0: o_a_edge = v;
         1: a_own = v;
         2: o_b_edge = v;
         default: b_own = v;
      endcase
      repeat (3) @(posedge i_clock);
   endtask
   // data ready after strobe
   task automatic ready;
      drive(0, 1'b0);
      drive(0, 1'b1);
   endtask
endmodule

// ==== testbench.sv ====
// testbench: bus tasks, scenarios and verdict for the port interrupt block
// assumes: peripheral_model drives the control lines
`timescale 1ns/100ps
module testbench;
   logic       i_clock, i_nrst, i_chip_select, i_chip_select_n, i_read_write, i_timer_underflow;
   logic       o_data_oe_n, o_irq_out, o_irq_oe_n, o_counter_load, o_port_a_strobe_line, o_port_a_strobe_oe_n;
   logic       o_port_b_strobe_line, o_port_b_strobe_oe_n, i_port_a_edge_input, i_port_a_strobe_line;
   logic       i_port_b_edge_input, i_port_b_strobe_line;
   logic [2:0] i_register_select;
   logic [7:0] i_data, o_data, rdata, o_port_a_output_reg, o_port_a_direction_reg, o_port_b_output_reg;
   logic [7:0] o_port_b_direction_reg, o_upper_latch, o_lower_reload_latch, o_timer_mode_control;
   logic [7:0] i_port_a_pins = 8'h5A, i_port_b_pins = 8'hA5, i_lower_count = 8'h3C, i_upper_count = 8'hC3;
   int         mismatches = 0, checked = 0, cycles = 0;
   port_control_line_interrupts i_port_control_line_interrupts (.i_clock, .i_nrst, .i_chip_select,
      .i_chip_select_n, .i_read_write, .i_register_select, .i_data, .o_data, .o_data_oe_n, .o_irq_out,
      .o_irq_oe_n, .i_port_a_edge_input, .i_port_a_strobe_line, .o_port_a_strobe_line, .o_port_a_strobe_oe_n,
      .i_port_b_edge_input, .i_port_b_strobe_line, .o_port_b_strobe_line, .o_port_b_strobe_oe_n,
      .i_port_a_pins, .i_port_b_pins, .o_port_a_output_reg, .o_port_a_direction_reg, .o_port_b_output_reg,
      .o_port_b_direction_reg, .i_timer_underflow, .i_lower_count, .i_upper_count, .o_upper_latch,
      .o_lower_reload_latch, .o_counter_load, .o_timer_mode_control);
   peripheral_model i_peripheral_model (.i_clock, .i_a_out(o_port_a_strobe_line),
      .i_a_oe_n(o_port_a_strobe_oe_n), .i_b_out(o_port_b_strobe_line), .i_b_oe_n(o_port_b_strobe_oe_n),
      .o_a_edge(i_port_a_edge_input), .o_a_line(i_port_a_strobe_line), .o_b_edge(i_port_b_edge_input),
      .o_b_line(i_port_b_strobe_line));
   // ----
   // shared tasks
   // ----
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic rw, input logic [2:0] rs, input logic [7:0] d);
      @(posedge i_clock);
      #1;
      {i_chip_select, i_chip_select_n, i_read_write, i_register_select, i_data} = {2'b10, rw, rs, d};
      @(posedge i_clock);
      #1;
      {i_chip_select, i_chip_select_n} = 2'b01;
      rdata = o_data;
   endtask
   task automatic uf_pulse;
      @(posedge i_clock);
      #1;
      i_timer_underflow = 1'b1;
      @(posedge i_clock);
      #1;
      i_timer_underflow = 1'b0;
   endtask
   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   task automatic wr(input logic [2:0] rs, input logic [7:0] d);
      acc(1'b0, rs, d);
   endtask
   task automatic rd(input logic [2:0] rs, input logic [7:0] exp);
      acc(1'b1, rs, 8'h00);
      chk(rdata, exp);
   endtask
   task automatic irq(input logic [7:0] exp);
      chk(8'(o_irq_oe_n), exp);
   endtask
   task automatic drv(input int n, input logic v);
      i_peripheral_model.drive(n, v);
   endtask
   task automatic t_timer;
      rd(3'h5, 8'h00);
      wr(3'h3, 8'h01);
      uf_pulse;
      irq(8'h01);
      rd(3'h3, 8'h9F);
      wr(3'h3, 8'h81);
      uf_pulse;
      irq(8'h00);
      acc(1'b1, 3'h3, 8'h00);
      rd(3'h3, 8'h1F);
      irq(8'h01);
      rd(3'h2, 8'h3C);
      wr(3'h2, 8'hE7);
      chk(o_lower_reload_latch, 8'hE7);
      rd(3'h0, 8'hC3);
      $display("timer done");
   endtask
   task automatic t_port_a;
      wr(3'h4, 8'h77);
      rd(3'h4, 8'h77);
      wr(3'h5, 8'h04);
      rd(3'h4, 8'h08);
      drv(0, 1'b0);
      rd(3'h5, 8'h84);
      irq(8'h01);
      wr(3'h5, 8'h05);
      irq(8'h00);
      drv(1, 1'b0);
      rd(3'h5, 8'hC5);
      acc(1'b1, 3'h4, 8'h00);
      rd(3'h5, 8'h05);
      irq(8'h01);
      wr(3'h5, 8'h1E);
      drv(0, 1'b1);
      drv(1, 1'b1);
      rd(3'h5, 8'hDE);
      irq(8'h00);
      wr(3'h5, 8'h16);
      irq(8'h01);
      acc(1'b1, 3'h4, 8'h00);
      $display("port a done");
   endtask
   task automatic t_port_b;
      wr(3'h7, 8'h0F);
      drv(2, 1'b0);
      rd(3'h7, 8'h0F);
      drv(2, 1'b1);
      drv(3, 1'b0);
      rd(3'h7, 8'hCF);
      irq(8'h00);
      acc(1'b1, 3'h6, 8'h00);
      rd(3'h7, 8'h0F);
      irq(8'h01);
      $display("port b done");
   endtask
   task automatic t_strobes;
      wr(3'h5, 8'h3C);
      chk({6'h0, o_port_a_strobe_oe_n, o_port_a_strobe_line}, 8'h01);
      wr(3'h5, 8'h34);
      chk({6'h0, o_port_a_strobe_oe_n, o_port_a_strobe_line}, 8'h00);
      wr(3'h5, 8'h2C);
      acc(1'b1, 3'h4, 8'h00);
      chk(8'(o_port_a_strobe_line), 8'h00);
      @(posedge i_clock);
      #1;
      chk(8'(o_port_a_strobe_line), 8'h01);
      wr(3'h5, 8'h24);
      acc(1'b1, 3'h4, 8'h00);
      repeat (3) @(posedge i_clock);
      #1;
      chk(8'(o_port_a_strobe_line), 8'h00);
      i_peripheral_model.ready;
      chk(8'(o_port_a_strobe_line), 8'h01);
      wr(3'h7, 8'h2C);
      wr(3'h6, 8'h99);
      chk(8'(o_port_b_strobe_line), 8'h00);
      chk(o_port_b_output_reg, 8'h99);
      @(posedge i_clock);
      #1;
      chk(8'(o_port_b_strobe_line), 8'h01);
      $display("strobes done");
   endtask
   // ----
   // clock, reset, sequence, timeout
   // ----
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end
   initial begin
      {i_nrst, i_chip_select, i_chip_select_n, i_read_write, i_timer_underflow} = 5'b00010;
      i_register_select = 3'h0;
      i_data = 8'h00;
      repeat (12) @(posedge i_clock);
      #1;
      i_nrst = 1'b1;
      t_timer;
      t_port_a;
      t_port_b;
      t_strobes;
      close_out;
   end
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         close_out;
      end
   end
endmodule
